/* File: rtl/hsef_regs.vh */
// Register map, field positions and constants of the event-flag block
`ifndef HSEF_REGS_VH
`define HSEF_REGS_VH
`define HSEF_ADDR_W        6
`define HSEF_OFF_CMD       6'h00
`define HSEF_OFF_STATUS    6'h24
`define HSEF_OFF_ENABLE    6'h28
`define HSEF_OFF_CLEAR     6'h0c
`define HSEF_OFF_FRAME     6'h10
`define HSEF_NFLAG         5
`define HSEF_FLG_DONE      0
`define HSEF_FLG_ERR       1
`define HSEF_FLG_PORT      2
`define HSEF_FLG_ROLL      3
`define HSEF_FLG_HSE       4
`define HSEF_STS_HALT      12
`define HSEF_CMD_RUN       0
`define HSEF_CMD_FLS_LO    2
`define HSEF_CMD_FLS_HI    3
`define HSEF_CMD_THR_LO    16
`define HSEF_CMD_THR_HI    23
`define HSEF_THR_RST       8'h08
`define HSEF_FLS_1024      2'h0
`define HSEF_FLS_512       2'h1
`define HSEF_FLS_256       2'h2
`define HSEF_WRAP_1024     14'h1fff
`define HSEF_WRAP_512      14'h0fff
`define HSEF_WRAP_256      14'h07ff
`define HSEF_FRIDX_W       14
`define HSEF_RESP_OKAY     2'h0
`define HSEF_RESP_SLVERR   2'h2
`endif

/* File: rtl/hsef_rise.v */
// Rising-edge detector over a vector of same-clock levels
`timescale 1ns/10ps
module hsef_rise #(
    parameter W = 1
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] level,
    output wire [W-1:0] rise
);
    reg [W-1:0] prev_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= {W{1'b0}};
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
endmodule // hsef_rise

/* File: rtl/hsef_flag.v */
// One sticky event flag: set or load beats a software clear
`timescale 1ns/10ps
module hsef_flag (
    input  wire aclk,
    input  wire aresetn,
    input  wire set,
    input  wire clr,
    input  wire load,
    input  wire load_val,
    output wire flag
);
    reg flag_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else if (load) begin
            flag_q <= load_val | set;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;
endmodule // hsef_flag

/* File: rtl/hsef_top.v */
// Host status event flags with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "hsef_regs.vh"
module hsef_top #(
    parameter NPORT   = 2,
    parameter D3_LOAD = 1
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [5:0]       s_axi_awaddr,
    input  wire [2:0]       s_axi_awprot,
    input  wire             s_axi_awvalid,
    output wire             s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output wire             s_axi_wready,
    output wire [1:0]       s_axi_bresp,
    output wire             s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [5:0]       s_axi_araddr,
    input  wire [2:0]       s_axi_arprot,
    input  wire             s_axi_arvalid,
    output wire             s_axi_arready,
    output wire [31:0]      s_axi_rdata,
    output wire [1:0]       s_axi_rresp,
    output wire             s_axi_rvalid,
    input  wire             s_axi_rready,
    input  wire             xfer_done_evt,
    input  wire             short_pkt_evt,
    input  wire             xfer_err_evt,
    input  wire             host_err_evt,
    input  wire [NPORT-1:0] port_change,
    input  wire [NPORT-1:0] port_resume,
    input  wire [NPORT-1:0] port_suspended,
    input  wire [NPORT-1:0] port_companion,
    input  wire             d3_exit,
    input  wire             uframe_tick,
    input  wire             sched_idle,
    output wire             run_stop,
    output wire             halted,
    output wire             irq
);
    ////////////////////////////////////////////////////////////////////////////////////
    reg                     awready_q;
    reg                     wready_q;
    reg                     bvalid_q;
    reg  [1:0]              bresp_q;
    reg                     arready_q;
    reg                     rvalid_q;
    reg  [1:0]              rresp_q;
    reg  [31:0]             rdata_q;
    reg                     aw_full_q;
    reg                     w_full_q;
    reg  [5:0]              waddr_q;
    reg  [31:0]             wdata_q;
    reg  [3:0]              wstrb_q;
    reg                     run_q;
    reg  [1:0]              fls_q;
    reg  [7:0]              thr_q;
    reg  [`HSEF_NFLAG-1:0]  en_q;
    reg                     halt_q;
    reg  [`HSEF_FRIDX_W-1:0] fidx_q;
    reg  [7:0]              ucnt_q;
    reg                     thr_irq_q;
    reg                     irq_q;
    wire                    wr_fire;
    wire [31:0]             wmask;
    wire [31:0]             wdm;
    wire                    wr_ok;
    wire [`HSEF_NFLAG-1:0]  flags;
    reg  [`HSEF_NFLAG-1:0]  clr_vec;
    wire [`HSEF_NFLAG-1:0]  set_vec;
    wire [`HSEF_NFLAG-1:0]  ld_vec;
    wire [NPORT-1:0]        chg_rise;
    wire [NPORT-1:0]        res_rise;
    wire [NPORT-1:0]        owned;
    reg  [`HSEF_FRIDX_W-1:0] wrap_val;
    wire                    fadv;
    wire                    roll;
    wire                    thr_hit;
    wire [`HSEF_NFLAG-1:0]  act;
    reg  [31:0]             rd_val;
    reg                     rd_ok;

    ////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in any order
    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    assign wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wdm     = wdata_q & wmask;
    assign wr_ok   = (waddr_q[5:2] == `HSEF_OFF_CMD    >> 2) ||
                     (waddr_q[5:2] == `HSEF_OFF_STATUS >> 2) ||
                     (waddr_q[5:2] == `HSEF_OFF_ENABLE >> 2) ||
                     (waddr_q[5:2] == `HSEF_OFF_CLEAR  >> 2);

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `HSEF_RESP_OKAY;
            waddr_q   <= 6'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                waddr_q   <= s_axi_awaddr;
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? `HSEF_RESP_OKAY : `HSEF_RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Command and enable registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            fls_q <= `HSEF_FLS_1024;
            thr_q <= `HSEF_THR_RST;
            en_q  <= {`HSEF_NFLAG{1'b0}};
        end else begin
            if (wr_fire && waddr_q[5:2] == (`HSEF_OFF_CMD >> 2)) begin
                if (wstrb_q[0]) begin
                    run_q <= wdata_q[`HSEF_CMD_RUN];
                    fls_q <= wdata_q[`HSEF_CMD_FLS_HI:`HSEF_CMD_FLS_LO];
                end
                if (wstrb_q[2]) begin
                    thr_q <= wdata_q[`HSEF_CMD_THR_HI:`HSEF_CMD_THR_LO];
                end
            end
            if (wr_fire && waddr_q[5:2] == (`HSEF_OFF_ENABLE >> 2) && wstrb_q[0]) begin
                en_q <= wdata_q[`HSEF_NFLAG-1:0];
            end
            if (host_err_evt) begin
                run_q <= 1'b0;
            end
        end
    end

    // Halted only after the schedule engine reports it has stopped
    always @(posedge aclk) begin
        if (!aresetn) begin
            halt_q <= 1'b1;
        end else if (run_q) begin
            halt_q <= 1'b0;
        end else if (sched_idle) begin
            halt_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Frame index and rollover detection
    always @* begin
        case (fls_q)
            `HSEF_FLS_512: wrap_val = `HSEF_WRAP_512;
            `HSEF_FLS_256: wrap_val = `HSEF_WRAP_256;
            default:       wrap_val = `HSEF_WRAP_1024;
        endcase
    end

    assign fadv = uframe_tick & run_q & ~halt_q;
    assign roll = fadv & ((fidx_q & wrap_val) == wrap_val);

    always @(posedge aclk) begin
        if (!aresetn) begin
            fidx_q <= {`HSEF_FRIDX_W{1'b0}};
        end else if (fadv) begin
            fidx_q <= fidx_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Event sources and sticky flags
    hsef_rise #(
        .W (NPORT)
    ) u_chg_rise (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (port_change),
        .rise    (chg_rise)
    );

    hsef_rise #(
        .W (NPORT)
    ) u_res_rise (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (port_resume),
        .rise    (res_rise)
    );

    assign owned = ~port_companion;
    assign set_vec[`HSEF_FLG_DONE] = xfer_done_evt | short_pkt_evt;
    assign set_vec[`HSEF_FLG_ERR]  = xfer_err_evt;
    assign set_vec[`HSEF_FLG_PORT] = |(chg_rise & owned) |
                                     |(res_rise & port_suspended & owned);
    assign set_vec[`HSEF_FLG_ROLL] = roll;
    assign set_vec[`HSEF_FLG_HSE]  = host_err_evt;

    assign ld_vec = (D3_LOAD != 0 && d3_exit) ? (1'b1 << `HSEF_FLG_PORT) : 5'h00;

    always @* begin
        clr_vec = {`HSEF_NFLAG{1'b0}};
        if (wr_fire && (waddr_q[5:2] == (`HSEF_OFF_STATUS >> 2) ||
                        waddr_q[5:2] == (`HSEF_OFF_CLEAR >> 2))) begin
            clr_vec = wdm[`HSEF_NFLAG-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `HSEF_NFLAG; gi = gi + 1) begin : g_flag
            hsef_flag u_flag (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .set      (set_vec[gi]),
                .clr      (clr_vec[gi]),
                .load     (ld_vec[gi]),
                .load_val (|(port_change | port_resume)),
                .flag     (flags[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////
    // Interrupt threshold pacing and interrupt output
    assign thr_hit = uframe_tick && (ucnt_q + 8'h01 >= thr_q);
    assign act     = flags & en_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ucnt_q    <= 8'h00;
            thr_irq_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            if (uframe_tick) begin
                ucnt_q <= thr_hit ? 8'h00 : ucnt_q + 8'h01;
            end
            if (act[`HSEF_FLG_DONE] == 1'b0 && act[`HSEF_FLG_ERR] == 1'b0) begin
                thr_irq_q <= 1'b0;
            end else if (thr_hit) begin
                thr_irq_q <= 1'b1;
            end
            irq_q <= thr_irq_q & (act[`HSEF_FLG_DONE] | act[`HSEF_FLG_ERR]) |
                     act[`HSEF_FLG_PORT] | act[`HSEF_FLG_ROLL] |
                     flags[`HSEF_FLG_HSE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    always @* begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b1;
        case (s_axi_araddr[5:2])
            (`HSEF_OFF_CMD >> 2): begin
                rd_val[`HSEF_CMD_RUN] = run_q;
                rd_val[`HSEF_CMD_FLS_HI:`HSEF_CMD_FLS_LO] = fls_q;
                rd_val[`HSEF_CMD_THR_HI:`HSEF_CMD_THR_LO] = thr_q;
            end
            (`HSEF_OFF_STATUS >> 2): begin
                rd_val[`HSEF_NFLAG-1:0] = flags;
                rd_val[`HSEF_STS_HALT]  = halt_q;
            end
            (`HSEF_OFF_ENABLE >> 2): rd_val[`HSEF_NFLAG-1:0] = en_q;
            (`HSEF_OFF_CLEAR >> 2):  rd_val = 32'h00000000;
            (`HSEF_OFF_FRAME >> 2):  rd_val[`HSEF_FRIDX_W-1:0] = fidx_q;
            default:                 rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `HSEF_RESP_OKAY;
            rdata_q   <= 32'h00000000;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_val;
            rresp_q   <= rd_ok ? `HSEF_RESP_OKAY : `HSEF_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign run_stop      = run_q;
    assign halted        = halt_q;
    assign irq           = irq_q;
endmodule // hsef_top

/* File: dv/hsef_monitor.sv */
// Port checker for the event-flag block
`timescale 1ns/10ps
module hsef_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        host_err_evt,
    input wire        sched_idle,
    input wire        run_stop,
    input wire        halted,
    input wire        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_hse_stops_run: assert property (host_err_evt |=> !run_stop)
        else $error("run_stop kept after host error");
    a_hse_raises_irq: assert property (host_err_evt |-> ##2 irq)
        else $error("no irq after host error");
    a_run_not_halted: assert property (run_stop |=> !halted)
        else $error("halted while running");
    a_stop_sets_halt: assert property (!run_stop && sched_idle |=> halted)
        else $error("halted missing when stopped");
    a_reset_values: assert property ($rose(aresetn) |->
        halted && !run_stop && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bad values after reset");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
endmodule // hsef_monitor

bind hsef_top hsef_monitor u_hsef_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .host_err_evt,
    .sched_idle, .run_stop, .halted, .irq);

/* File: dv/hsef_top_tb_top.sv */
// Self-checking bench for the event-flag block
`timescale 1ns/10ps
module hsef_top_tb_top;
    reg        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    reg        xd = 0, sp = 0, xe = 0, he = 0, d3 = 0, tk = 0, idle = 1;
    reg  [5:0] awa = 0, ara = 0;
    reg [31:0] wd = 0, g, seed;
    reg  [3:0] ws = 0;
    reg  [1:0] pc = 0, pr = 0, ps = 0, po = 0, gr;
    wire       awr, wrd, bv, arr, rv, run_o, hl, irq;
    wire [1:0] br, rr;
    wire[31:0] rd;
    int        mismatches = 0, samples_checked = 0, idx, m, fc;
    // Byte addresses of the register map
    localparam [5:0] ad_cmd = 6'h00, ad_sts = 6'h24, ad_ena = 6'h28, ad_clr = 6'h0c;
    localparam [5:0] ad_frm = 6'h10;

    hsef_top u_hsef_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .xfer_done_evt(xd), .short_pkt_evt(sp),
        .xfer_err_evt(xe), .host_err_evt(he), .port_change(pc), .port_resume(pr),
        .port_suspended(ps), .port_companion(po), .d3_exit(d3), .uframe_tick(tk),
        .sched_idle(idle), .run_stop(run_o), .halted(hl), .irq(irq));

    initial forever #50 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, v);
        end
    endtask
    task tmo(input bit ok);
        if (!ok) begin
            mismatches++;
            $display("mismatch handshake expected done seen timeout");
            summarize;
        end
    endtask
    task step;
        @(posedge aclk);
        #1;
    endtask
    // rc drives the done event into the clear's effect edge
    task wr(input [5:0] a, input [31:0] d, input bit rc);
        int n;
        bit ah, wh, ta, tw, tb;
        awa <= a; wd <= d; ws <= 4'hf; awv <= 1; wv <= 1; bry <= 1;
        ah = 0; wh = 0; tb = 0; n = 0;
        while (!(ah && wh) && n < 200) begin
            ta = awr; tw = wrd; step; n++;
            if (ta && !ah) begin ah = 1; awv <= 0; end
            if (tw && !wh) begin wh = 1; wv <= 0; end
        end
        tmo(ah && wh);
        if (rc) begin xd <= 1; step; xd <= 0; end
        n = 0;
        while (!tb && n < 200) begin tb = bv; gr = br; step; n++; end
        bry <= 0; tmo(tb); step;
    endtask
    task rdr(input [5:0] a);
        int n;
        bit t;
        ara <= a; arv <= 1; rry <= 1; n = 0; t = 0;
        while (!t && n < 200) begin t = arr; step; n++; end
        arv <= 0; tmo(t); n = 0; t = 0;
        while (!t && n < 200) begin t = rv; g = rd; gr = rr; step; n++; end
        rry <= 0; tmo(t); step;
    endtask
    task rc(input string nm, input [5:0] a, input [31:0] e);
        rdr(a);
        chk(nm, e, g);
    endtask
    task tick(input int n);
        repeat (n) begin tk <= 1; step; tk <= 0; step; end
    endtask
    task ev(input int k);
        case (k)
            0: xd <= 1;
            1: sp <= 1;
            2: xe <= 1;
            3: pc[0] <= 1;
            4: pr[0] <= 1;
            default: he <= 1;
        endcase
        step; {xd, sp, xe, he} <= 0; pc <= 0; pr <= 0; step;
    endtask
    function [31:0] sts(input [4:0] f, input h);
        sts = {19'h0, h, 7'h0, f};
    endfunction
    function [4:0] fm(input int k);
        fm = (k < 2) ? 5'h01 : (k == 2) ? 5'h02 : (k < 5) ? 5'h04 : 5'h10;
    endfunction
    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h31b0b742;
        repeat (10) @(posedge aclk);
        #1; aresetn <= 1;
        rc("status", ad_sts, sts(0, 1));
        rc("cmd", ad_cmd, 32'h00080000);
        rc("enable", ad_ena, 0);
        idx = 0;
        // List size codes 2, 1, 0, 3 in turn
        for (int c = 0; c < 4; c++) begin
            fc = (2 - c) & 3;
            m = (fc == 2) ? 32'h7ff : (fc == 1) ? 32'hfff : 32'h1fff;
            wr(ad_cmd, 32'h00080001 | (fc << 2), 0);
            m = m - (idx & m);
            tick(m);
            idx += m;
            rc("frame", ad_frm, idx);
            rc("no roll", ad_sts, sts(0, 0));
            tick(1);
            idx++;
            rc("roll", ad_sts, sts(5'h08, 0));
            wr(ad_sts, 32'h8, 0);
        end
        ps[0] <= 1;
        for (int k = 0; k < 6; k++) begin
            ev(k);
            rc("flag set", ad_sts, sts(fm(k), k == 5));
            wr(ad_sts, 0, 0);
            chk("bresp", 0, gr);
            rc("flag kept", ad_sts, sts(fm(k), k == 5));
            if (k == 5) chk("run_stop", 0, run_o);
            if (k == 5) chk("irq", 1, irq);
            wr(k[0] ? ad_clr : ad_sts, {27'h0, fm(k)}, 0);
            rc("flag clear", ad_sts, sts(0, k == 5));
        end
        // Halted follows the schedule engine, not run/stop alone
        idle <= 0;
        wr(ad_cmd, 32'h00080001, 0);
        chk("run_stop", 1, run_o);
        chk("halted run", 0, hl);
        wr(ad_cmd, 32'h00080000, 0);
        chk("halted busy", 0, hl);
        idle <= 1;
        step;
        step;
        chk("halted idle", 1, hl);
        ps <= 0; po <= 2'b10; pc <= 2'b10; pr <= 2'b01; step;
        rc("companion", ad_sts, sts(0, 1));
        pr <= 0;
        wr(ad_ena, 32'h4, 0); pc <= 2'b01; repeat (3) step;
        chk("irq port", 1, irq);
        wr(ad_ena, 0, 0);
        chk("irq masked", 0, irq);
        wr(ad_clr, 32'h4, 0); d3 <= 1; step; d3 <= 0; step;
        rc("d3 load", ad_sts, sts(5'h04, 1));
        pc <= 0; wr(ad_clr, 32'h4, 0);
        wr(ad_ena, 32'h1, 0); ev(0);
        tick(7);
        chk("irq early", 0, irq);
        tick(1); step;
        chk("irq boundary", 1, irq);
        wr(ad_clr, 32'h1, 0);
        wr(ad_sts, 32'h1, 1);
        rc("set over clear", ad_sts, sts(5'h01, 1));
        wr(ad_cmd, 32'h00020000, 0);
        tick(1);
        chk("irq thr one", 0, irq);
        tick(1);
        chk("irq thr two", 1, irq);
        rdr(6'h3c);
        chk("rresp", 2, gr);
        chk("rdata", 0, g);
        wr(6'h3c, 32'hffffffff, 0);
        chk("bresp", 2, gr);
        repeat (6) begin
            seed = xs(seed);
            wr(ad_ena, seed, 0);
            rc("enable", ad_ena, seed & 32'h1f);
        end
        // Reset again with a flag standing
        aresetn <= 0;
        repeat (2) step;
        aresetn <= 1;
        rc("status reset", ad_sts, sts(0, 1));
        rc("cmd reset", ad_cmd, 32'h00080000);
        summarize;
    end
endmodule // hsef_top_tb_top
